// ### rtl/rbmc_pkg.sv
// Constants and types for the backup mode control block
package rbmc_pkg;
   localparam int ADDR_W = 28;
   localparam int DATA_W = 8;
   // Register byte addresses
   localparam logic [27:0] BMC_ADDR = 28'hffffb00;
   localparam logic [27:0] SCM_ADDR = 28'hffffb03;
   localparam logic [27:0] PROT_ADDR = 28'hffffb04;
   localparam logic [27:0] STAT_ADDR = 28'hffffb05;
   // Field positions
   localparam int BMC_EN_BIT = 0;
   localparam int BMC_SET_BIT = 1;
   localparam int SCM_LP_BIT = 0;
   localparam int STAT_PB_BIT = 0;
   localparam int STAT_PERR_BIT = 1;
   localparam int STAT_SEQ_BIT = 2;
   localparam int STAT_WDX_BIT = 3;
   // Writable bit masks and reset values
   localparam logic [7:0] BMC_MASK = 8'h03;
   localparam logic [7:0] SCM_MASK = 8'h01;
   localparam logic [7:0] BMC_RST = 8'h00;
   localparam logic [7:0] SCM_RST = 8'h00;
   localparam logic [7:0] STAT_MASK = 8'h0e;
   // Pre-backup state of the block
   typedef enum logic [0:0] {
      RBMC_NORMAL,
      RBMC_PRE_BACKUP
   } rbmc_state_t;
endpackage : rbmc_pkg

// ### rtl/rbmc_prot_gate.sv
// Protected write gate: an arming write opens exactly one next write
`timescale 1ns/1ps
`default_nettype none
module rbmc_prot_gate (
   input wire logic CORE_CLK_I,
   input wire logic RESET_N_I,
   input wire logic SYS_RESET_I,
   input wire logic WR_I,
   input wire logic [rbmc_pkg::ADDR_W-1:0] ADDR_I,
   output logic PASS_O,
   output logic FAIL_O
);
   import rbmc_pkg::*;

   logic armed_q;
   logic is_prot;
   logic is_cmd;
   logic [ADDR_W-1:0] last_addr_q;
   logic last_valid_q;

   // Decode of protected targets and the arming command
   assign is_prot = (ADDR_I == BMC_ADDR) || (ADDR_I == SCM_ADDR);
   assign is_cmd = (ADDR_I == PROT_ADDR);

   // Arm on command write; any other write consumes the arming
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         armed_q <= 1'b0;
      end else if (SYS_RESET_I) begin
         armed_q <= 1'b0;
      end else if (WR_I) begin
         armed_q <= is_cmd;
      end
   end

   // Pass only the write right after arming
   assign PASS_O = WR_I && is_prot && armed_q;
   assign FAIL_O = WR_I && is_prot && !armed_q;

   // Address of the latest write, idle gaps allowed
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         last_addr_q <= '0;
         last_valid_q <= 1'b0;
      end else if (WR_I) begin
         last_addr_q <= ADDR_I;
         last_valid_q <= !SYS_RESET_I;
      end else if (SYS_RESET_I) begin
         last_valid_q <= 1'b0;
      end
   end

   // R5: protected access
   property p_prot_pass;
      @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      PASS_O |-> last_valid_q && (last_addr_q == PROT_ADDR);
   endproperty
   a_prot_pass: assert property (p_prot_pass) // R5
      else $error("protected write passed without arming");
endmodule : rbmc_prot_gate
`default_nettype wire

// ### rtl/rbmc_top.sv
// Backup mode control: protected registers and pre-backup state
//
// Function
// R1: Backup mode is usable only while the backup enable bit is 1.
// R2: Pre-backup set switches counter to divided subclock, halts irq, pin, correction.
// R3: Writing 0 to the pre-backup set bit leaves pre-backup; exit here also needs subclock mode bit 0.
// R4: Backup supply power-on reset clears both registers; other resets retain.
// R5: Both registers change only through the protected write sequence; here a watchdog exit also clears the set bit without it.
// R6: Registers accept whole-byte and single-bit reads and writes.
// R7: Software sets enable first, then pre-backup set, never together.
// R8: Set bit written while disabled reads 1 but does not enter pre-backup.
// R9: Subclock mode bit 0: normal oscillation, 1: ultra-low consumption.
// R10: Software writes zeros to subclock mode bits 7 to 1.
// R11: Enable 1 and set 1 enter pre-backup; low-power subclock optional.
// R12: Subclock bit 0 and set bit 0 leave pre-backup.
// R13: Software prepares backup only while running on the main clock.
// R14: Init: enable, normal subclock, clear set bit, one NOP, all protected.
// R15: Software makes the low-voltage detector interrupt at a chosen level.
// R16: Interrupt routine checks low-voltage flag; enters only when flag is 1.
// R17: Routine slows clock, blocks DMA, NMI, watchdog, irqs, then sets bits, STOP.
// R18: Locked watchdog reset leaves pre-backup via software re-initialisation.
// R19: Watchdog interrupt while in pre-backup takes the block out.
// R20: System reset before set bit is written prevents backup entry.
// R21: Software selects subclock for the counter and then starts it.
// R22: After external reset following backup, software repeats initial settings.
`timescale 1ns/1ps
`default_nettype none
module rbmc_top (
   input wire logic CORE_CLK_I,
   input wire logic RESET_N_I,
   input wire logic SYS_RESET_I,
   input wire logic [rbmc_pkg::ADDR_W-1:0] ADDR_I,
   input wire logic [rbmc_pkg::DATA_W-1:0] WDATA_I,
   input wire logic [rbmc_pkg::DATA_W-1:0] WMASK_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic WDT_IRQ_I,
   output logic [rbmc_pkg::DATA_W-1:0] RDATA_O,
   output logic BACKUP_ALLOWED_O,
   output logic PRE_BACKUP_O,
   output logic RTC_SUBCLK_DIV_SEL_O,
   output logic RTC_IRQ_HALT_O,
   output logic RTC_PIN_HALT_O,
   output logic RTC_CORR_HALT_O,
   output logic SUBCLK_LOW_POWER_O
);
   import rbmc_pkg::*;

   logic [7:0] bmc_q;
   logic [7:0] bmc_d;
   logic [7:0] scm_q;
   logic [7:0] scm_d;
   logic [7:0] stat_q;
   logic [7:0] stat_d;
   logic [7:0] rdata_d;
   logic prot_pass;
   logic prot_fail;
   logic wr_bmc;
   logic wr_scm;
   logic wr_stat;
   logic en_bit;
   logic set_bit;
   logic lp_bit;
   logic wdt_exit;
   logic seq_viol;
   logic halt_q;
   logic halt_d;
   rbmc_state_t state_q;
   rbmc_state_t state_d;

   // Protected write sequence checker
   rbmc_prot_gate u_gate (
      .CORE_CLK_I(CORE_CLK_I),
      .RESET_N_I(RESET_N_I),
      .SYS_RESET_I(SYS_RESET_I),
      .WR_I(WR_I),
      .ADDR_I(ADDR_I),
      .PASS_O(prot_pass),
      .FAIL_O(prot_fail)
   );

   // Write decode; protected targets need the gate
   // R5: protected writes only
   assign wr_bmc = prot_pass && (ADDR_I == BMC_ADDR);
   assign wr_scm = prot_pass && (ADDR_I == SCM_ADDR);
   assign wr_stat = WR_I && (ADDR_I == STAT_ADDR);

   assign en_bit = bmc_q[BMC_EN_BIT];
   assign set_bit = bmc_q[BMC_SET_BIT];
   assign lp_bit = scm_q[SCM_LP_BIT];

   // R19: watchdog interrupt exit
   assign wdt_exit = WDT_IRQ_I && (state_q == RBMC_PRE_BACKUP);

   // Both bits rising from 0 in one write
   assign seq_viol = wr_bmc && WMASK_I[BMC_EN_BIT] && WMASK_I[BMC_SET_BIT]
      && WDATA_I[BMC_EN_BIT] && WDATA_I[BMC_SET_BIT] && !en_bit && !set_bit;

   // Next control byte: masked merge gives byte and bit writes
   always_comb begin
      bmc_d = bmc_q;
      // R19: drop set bit on watchdog exit
      if (wdt_exit) begin
         bmc_d[BMC_SET_BIT] = 1'b0;
      end
      // R6: byte or single-bit write
      if (wr_bmc) begin
         bmc_d = ((bmc_q & ~WMASK_I) | (WDATA_I & WMASK_I)) & BMC_MASK;
      end
   end

   // Next subclock mode byte; upper bits never stored
   always_comb begin
      scm_d = scm_q;
      // R9: bit 0 selects oscillator mode
      if (wr_scm) begin
         scm_d = ((scm_q & ~WMASK_I) | (WDATA_I & WMASK_I)) & SCM_MASK;
      end
   end

   // Control registers: only backup supply reset clears them
   // R4: retained over system reset
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         bmc_q <= BMC_RST;
         scm_q <= SCM_RST;
      end else begin
         bmc_q <= bmc_d;
         scm_q <= scm_d;
      end
   end

   // Pre-backup state transitions
   always_comb begin
      state_d = state_q;
      case (state_q)
         RBMC_NORMAL: begin
            // R11: enable and set enter
            // R8: set without enable stays out
            if (en_bit && set_bit) begin
               state_d = RBMC_PRE_BACKUP;
            end
         end
         RBMC_PRE_BACKUP: begin
            // R12: normal subclock and set cleared leave
            // R3: clearing set bit exits once subclock bit is 0
            if (wdt_exit || (!lp_bit && !set_bit)) begin
               state_d = RBMC_NORMAL;
            end
         end
         default: begin
            state_d = RBMC_NORMAL;
         end
      endcase
   end

   // State register follows the retained bits across system reset
   // R20: no entry without set bit
   // R18: state kept for re-init
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         state_q <= RBMC_NORMAL;
      end else begin
         state_q <= state_d;
      end
   end

   // Counter reconfiguration follows the state
   // R2: counter switch and halts
   assign halt_d = (state_d == RBMC_PRE_BACKUP);

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         halt_q <= 1'b0;
      end else begin
         halt_q <= halt_d;
      end
   end

   // Sticky status flags; hardware set wins over software clear
   always_comb begin
      stat_d = stat_q;
      if (wr_stat) begin
         stat_d = stat_q & ~(WDATA_I & STAT_MASK);
      end
      if (prot_fail) begin
         stat_d[STAT_PERR_BIT] = 1'b1;
      end
      if (seq_viol) begin
         stat_d[STAT_SEQ_BIT] = 1'b1;
      end
      if (wdt_exit) begin
         stat_d[STAT_WDX_BIT] = 1'b1;
      end
      stat_d[STAT_PB_BIT] = 1'b0;
   end

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         stat_q <= 8'h00;
      end else if (SYS_RESET_I) begin
         stat_q <= 8'h00;
      end else begin
         stat_q <= stat_d;
      end
   end

   // Read mux; unmapped addresses read zero
   // R6: byte reads
   always_comb begin
      rdata_d = 8'h00;
      if (RD_I) begin
         case (ADDR_I)
            BMC_ADDR: rdata_d = bmc_q;
            SCM_ADDR: rdata_d = scm_q;
            STAT_ADDR: begin
               rdata_d = stat_q;
               rdata_d[STAT_PB_BIT] = (state_q == RBMC_PRE_BACKUP);
            end
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // Read data stands one cycle after the strobe
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         RDATA_O <= 8'h00;
      end else begin
         RDATA_O <= rdata_d;
      end
   end

   // Outputs to the counter, oscillator and power control
   // R1: backup availability
   assign BACKUP_ALLOWED_O = en_bit;
   assign PRE_BACKUP_O = halt_q;
   assign RTC_SUBCLK_DIV_SEL_O = halt_q;
   assign RTC_IRQ_HALT_O = halt_q;
   assign RTC_PIN_HALT_O = halt_q;
   assign RTC_CORR_HALT_O = halt_q;
   assign SUBCLK_LOW_POWER_O = lp_bit;

   // Checks
   property p_allowed;
      @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      PRE_BACKUP_O |-> BACKUP_ALLOWED_O || $past(BACKUP_ALLOWED_O);
   endproperty
   a_allowed: assert property (p_allowed) // R1
      else $error("pre-backup without enable");

   property p_rtc_switch;
      @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      $rose(PRE_BACKUP_O) |-> RTC_SUBCLK_DIV_SEL_O && RTC_IRQ_HALT_O
         && RTC_PIN_HALT_O && RTC_CORR_HALT_O && $past(set_bit);
   endproperty
   a_rtc_switch: assert property (p_rtc_switch) // R2
      else $error("counter not reconfigured on entry");

   property p_exit_clear;
      @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      PRE_BACKUP_O && !set_bit && !lp_bit && !WDT_IRQ_I |=> !PRE_BACKUP_O;
   endproperty
   a_exit_clear: assert property (p_exit_clear) // R3
      else $error("no exit after set bit cleared");

   property p_por_clear;
      @(posedge CORE_CLK_I)
      $rose(RESET_N_I) |-> bmc_q == BMC_RST && scm_q == SCM_RST;
   endproperty
   a_por_clear: assert property (p_por_clear) // R4
      else $error("registers not cleared by power-on reset");

   property p_sys_keep;
      @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      SYS_RESET_I && !prot_pass && !WDT_IRQ_I |=> $stable(bmc_q)
         && $stable(scm_q);
   endproperty
   a_sys_keep: assert property (p_sys_keep) // R4
      else $error("register lost over system reset");

   property p_unprot;
      @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      !prot_pass |=> $stable(scm_q);
   endproperty
   a_unprot: assert property (p_unprot) // R5
      else $error("subclock mode changed without protection");

   property p_bit_write;
      @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      wr_scm && !WMASK_I[SCM_LP_BIT] |=> $stable(scm_q);
   endproperty
   a_bit_write: assert property (p_bit_write) // R6
      else $error("masked bit was written");

   property p_no_entry;
      @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      !PRE_BACKUP_O && !en_bit |=> !PRE_BACKUP_O;
   endproperty
   a_no_entry: assert property (p_no_entry) // R8
      else $error("entered pre-backup while disabled");

   property p_lp_out;
      @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      wr_scm && WMASK_I[SCM_LP_BIT] |=>
         SUBCLK_LOW_POWER_O == $past(WDATA_I[SCM_LP_BIT]) && scm_q[7:1] == 7'h00;
   endproperty
   a_lp_out: assert property (p_lp_out) // R9
      else $error("oscillator mode not taken");

   property p_enter;
      @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      !PRE_BACKUP_O && en_bit && set_bit |=> PRE_BACKUP_O;
   endproperty
   a_enter: assert property (p_enter) // R11
      else $error("no entry with enable and set");

   property p_hold;
      @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      PRE_BACKUP_O && lp_bit && !WDT_IRQ_I |=> PRE_BACKUP_O;
   endproperty
   a_hold: assert property (p_hold) // R12
      else $error("left pre-backup with low-power subclock");

   property p_wdt;
      @(posedge CORE_CLK_I) disable iff (!RESET_N_I)
      PRE_BACKUP_O && WDT_IRQ_I && !wr_bmc |=> !PRE_BACKUP_O ##1
         !PRE_BACKUP_O;
   endproperty
   a_wdt: assert property (p_wdt) // R19
      else $error("watchdog interrupt did not exit");

   c_enter: cover property (@(posedge CORE_CLK_I) $rose(PRE_BACKUP_O));
   c_exit: cover property (@(posedge CORE_CLK_I) $fell(PRE_BACKUP_O));
   c_wdt: cover property (@(posedge CORE_CLK_I) wdt_exit);
   c_fail: cover property (@(posedge CORE_CLK_I) prot_fail);
endmodule : rbmc_top
`default_nettype wire

// ### bench/rtc_backup_mode_control_tb.sv
// Self-checking testbench for the backup mode control block
`timescale 1ns/1ps
`default_nettype none
module rtc_backup_mode_control_tb;
   import rbmc_pkg::*;
   logic clk, rst_n, sys_rst, wr, rd, wdt_irq;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, wmask, rdata;
   logic allowed, pre, div_sel, irq_halt, pin_halt, corr_halt, low_pw;
   logic [7:0] outs;
   int errors;
   int samples_checked;

   // Device under test
   rbmc_top dut (
      .CORE_CLK_I(clk), .RESET_N_I(rst_n), .SYS_RESET_I(sys_rst),
      .ADDR_I(addr), .WDATA_I(wdata), .WMASK_I(wmask), .WR_I(wr),
      .RD_I(rd), .WDT_IRQ_I(wdt_irq), .RDATA_O(rdata),
      .BACKUP_ALLOWED_O(allowed), .PRE_BACKUP_O(pre),
      .RTC_SUBCLK_DIV_SEL_O(div_sel), .RTC_IRQ_HALT_O(irq_halt),
      .RTC_PIN_HALT_O(pin_halt), .RTC_CORR_HALT_O(corr_halt),
      .SUBCLK_LOW_POWER_O(low_pw)
   );
   // Output flags packed as enable, state, four counter controls, low power
   assign outs = {1'b0, allowed, pre, div_sel, irq_halt, pin_halt,
                  corr_halt, low_pw};

   // Clock and time-zero values
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Closing report and verdict
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string name, input logic [7:0] exp,
                      input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One write cycle; the edge after the strobe takes it
   task automatic wr_reg(input logic [27:0] a, input logic [7:0] d,
                         input logic [7:0] m);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      wmask <= m;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // Arming write followed by the target write
   task automatic prot(input logic [27:0] a, input logic [7:0] d,
                       input logic [7:0] m);
      wr_reg(PROT_ADDR, 8'h00, 8'hff);
      wr_reg(a, d, m);
   endtask : prot

   // Read cycle; data stand only in the following cycle
   task automatic rd_chk(input string name, input logic [27:0] a,
                         input logic [7:0] exp, input logic [7:0] m);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(name, exp, rdata & m);
   endtask : rd_chk

   // Let a stored write reach the state register
   task automatic outs_chk(input logic [7:0] exp);
      repeat (2) @(posedge clk);
      #1;
      chk("outputs", exp, outs);
   endtask : outs_chk

   task automatic pulse_sys_reset();
      @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
   endtask : pulse_sys_reset

   task automatic t_reset_values();
      rd_chk("bmc", BMC_ADDR, 8'h00, 8'hff);
      rd_chk("scm", SCM_ADDR, 8'h00, 8'hff);
      outs_chk(8'h00);
      rd_chk("unmapped", 28'hffffb07, 8'h00, 8'hff);
      rd_chk("arm reg", PROT_ADDR, 8'h00, 8'hff);
      $display("test reset_values done");
   endtask : t_reset_values

   task automatic t_unprotected();
      wr_reg(BMC_ADDR, 8'h01, 8'hff);
      rd_chk("bmc", BMC_ADDR, 8'h00, 8'hff);
      rd_chk("fail flag", STAT_ADDR, 8'h02, 8'h02);
      wr_reg(PROT_ADDR, 8'h00, 8'hff);
      pulse_sys_reset();
      wr_reg(SCM_ADDR, 8'h01, 8'hff);
      rd_chk("scm", SCM_ADDR, 8'h00, 8'hff);
      $display("test unprotected done");
   endtask : t_unprotected

   task automatic t_set_before_enable();
      prot(BMC_ADDR, 8'h02, 8'h02);
      rd_chk("bmc", BMC_ADDR, 8'h02, 8'hff);
      outs_chk(8'h00);
      prot(BMC_ADDR, 8'h01, 8'h01);
      outs_chk(8'h7e);
      rd_chk("bmc", BMC_ADDR, 8'h03, 8'hff);
      rd_chk("state", STAT_ADDR, 8'h01, 8'h01);
      $display("test set_before_enable done");
   endtask : t_set_before_enable

   task automatic t_exit_needs_both();
      prot(SCM_ADDR, 8'h01, 8'hff);
      outs_chk(8'h7f);
      prot(BMC_ADDR, 8'h00, 8'h02);
      outs_chk(8'h7f);
      rd_chk("state", STAT_ADDR, 8'h01, 8'h01);
      prot(SCM_ADDR, 8'h00, 8'hff);
      outs_chk(8'h40);
      $display("test exit_needs_both done");
   endtask : t_exit_needs_both

   task automatic t_watchdog_exit();
      prot(BMC_ADDR, 8'h02, 8'h02);
      outs_chk(8'h7e);
      @(posedge clk);
      wdt_irq <= 1'b1;
      @(posedge clk);
      wdt_irq <= 1'b0;
      outs_chk(8'h40);
      rd_chk("bmc", BMC_ADDR, 8'h01, 8'hff);
      rd_chk("wdt flag", STAT_ADDR, 8'h08, 8'h08);
      $display("test watchdog_exit done");
   endtask : t_watchdog_exit

   task automatic t_resets();
      prot(SCM_ADDR, 8'h01, 8'hff);
      prot(BMC_ADDR, 8'h02, 8'h02);
      outs_chk(8'h7f);
      pulse_sys_reset();
      outs_chk(8'h7f);
      rd_chk("bmc", BMC_ADDR, 8'h03, 8'hff);
      // Initial settings repeated after the reset
      prot(BMC_ADDR, 8'h01, 8'hff);
      prot(SCM_ADDR, 8'h00, 8'hff);
      prot(BMC_ADDR, 8'h00, 8'h02);
      outs_chk(8'h40);
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("outputs", 8'h00, outs);
      rd_chk("bmc", BMC_ADDR, 8'h00, 8'hff);
      rd_chk("scm", SCM_ADDR, 8'h00, 8'hff);
      // Both bits in one write flag the misuse
      prot(BMC_ADDR, 8'h03, 8'hff);
      rd_chk("seq flag", STAT_ADDR, 8'h04, 8'h04);
      $display("test resets done");
   endtask : t_resets

   // Main sequence
   initial begin
      errors = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      sys_rst = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      wdt_irq = 1'b0;
      addr = '0;
      wdata = '0;
      wmask = '0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_values();
      t_unprotected();
      t_set_before_enable();
      t_exit_needs_both();
      t_watchdog_exit();
      t_resets();
      stop_test();
   end

   // Hang guard, well beyond the roughly 120 cycles used
   initial begin
      #100000;
      errors++;
      stop_test();
   end
endmodule : rtc_backup_mode_control_tb
`default_nettype wire
